// ==== design/ers_status_reporter.sv ====
// E1 receive status reporter: overhead and status bytes on control channels 16 to 21
`timescale 1ns/1ps
`default_nettype none
module ers_status_reporter #(
	parameter int unsigned CYCLES_PER_MS = ers_pkg::CYCLES_PER_MS
) (
	input wire logic sys_clk_i,                  // 100 MHz system clock
	input wire logic arst_n_i,                   // Asynchronous reset, active low
	input wire logic bp_clk_i,                   // Backplane bit clock pin
	input wire logic bp_frame_i,                 // Backplane frame pulse pin, active high
	input wire logic external_status_input_i,    // External status pin
	input wire logic maint_enable_i,             // Maintenance option active
	input wire ers_pkg::ers_rx_t rx_i,           // Framer events and levels
	output logic control_status_out_stream_o     // Serial control output stream
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_s1_q;
	logic rst_n;

	// Two flops so every state flop leaves reset on the same edge
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Millisecond base

	logic ms_tick;

	ers_ms_tick #(
		.CYCLES(CYCLES_PER_MS)
	) u_ms_tick (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.tick_o(ms_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Derived terms

	ers_pkg::ers_state_t st_q;
	ers_pkg::ers_state_t st_d;
	logic bit_en;
	logic frame_edge;
	logic [7:0] nxt_cnt;
	logic marker;
	logic interval_end;
	logic [7:0] status1;
	logic [7:0] status2;

	// Backplane bit edge, taken from the synchronised copies only
	assign bit_en = st_q.clk_s2 & ~st_q.clk_s3;
	assign frame_edge = bit_en & st_q.frm_s2;
	assign nxt_cnt = st_q.frm_s2 ? 8'h00 : st_q.bit_cnt + 8'h01;

	// One-second interval marker is high for its first 8 ms
	assign marker = st_q.sec_ms < ers_pkg::MARK_END;
	assign interval_end = ms_tick & (st_q.sec_ms == ers_pkg::MARK_LAST);

	// Primary status byte, assembled from live levels, held toggles and the frame-sampled external status
	always_comb begin
		status1 = 8'h00;
		status1[ers_pkg::S1_FRAME_LOST] = rx_i.frame_sync_lost;
		status1[ers_pkg::S1_MF_LOST] = rx_i.multiframe_sync_lost;
		status1[ers_pkg::S1_FAS_ERR] = st_q.fas_err_tog;
		status1[ers_pkg::S1_SLIP] = st_q.slip_tog;
		status1[ers_pkg::S1_AIS] = rx_i.all_ones_alarm;
		status1[ers_pkg::S1_TS16_AIS] = rx_i.ts16_all_ones;
		status1[ers_pkg::S1_EXT] = st_q.ext_sample;
	end

	// Secondary status byte; bits 5 and 4 stay zero
	always_comb begin
		status2 = 8'h00;
		status2[ers_pkg::S2_SPARE15] = st_q.spare15;
		status2[ers_pkg::S2_SPARE13] = st_q.spare13;
		status2[ers_pkg::S2_MARKER] = marker;
		status2[ers_pkg::S2_CRC_TIMEOUT] = st_q.crc_timeout;
		status2[ers_pkg::S2_CRC_LOST] = rx_i.crc_multiframe_lost;
		status2[ers_pkg::S2_PHASE_B8] = st_q.phase_b8;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [7:0] sel;
		logic wrap_up;
		logic wrap_down;
		sel = ers_pkg::IDLE_BYTE;
		wrap_up = 1'b0;
		wrap_down = 1'b0;
		st_d = st_q;

		// Pin synchronisers; first stages feed only second stages
		st_d.clk_s1 = bp_clk_i;
		st_d.clk_s2 = st_q.clk_s1;
		st_d.clk_s3 = st_q.clk_s2;
		st_d.frm_s1 = bp_frame_i;
		st_d.frm_s2 = st_q.frm_s1;
		st_d.ext_s1 = external_status_input_i;
		st_d.ext_s2 = st_q.ext_s1;

		// Timeslot 0 capture, split by frame type
		if (rx_i.ts0_valid) begin
			if (rx_i.ts0_alignment) begin
				st_d.align_byte = rx_i.ts0_byte;
			end else begin
				st_d.nonalign_byte = rx_i.ts0_byte;
			end
		end

		// Alignment error toggle with hold-off so software sees at most one per window
		if (ms_tick && st_q.holdoff_ms != ers_pkg::HOLDOFF_DONE) begin
			st_d.holdoff_ms = st_q.holdoff_ms + 8'h01;
		end
		if (rx_i.fas_error && st_q.fas_err_cnt != ers_pkg::FAS_ERR_THRESH) begin
			st_d.fas_err_cnt = st_q.fas_err_cnt + 5'h01;
		end
		if (st_q.fas_err_cnt == ers_pkg::FAS_ERR_THRESH &&
				st_q.holdoff_ms == ers_pkg::HOLDOFF_DONE) begin
			st_d.fas_err_tog = ~st_q.fas_err_tog;
			st_d.fas_err_cnt = {4'h0, rx_i.fas_error}; // An error in this cycle is kept
			st_d.holdoff_ms = 8'h00;
		end

		// Slip toggle
		if (rx_i.slip) begin
			st_d.slip_tog = ~st_q.slip_tog;
		end

		// External status sampled at the frame pulse only
		if (frame_edge) begin
			st_d.ext_sample = st_q.ext_s2;
		end

		// Transmit phase: frame position at the 8 kHz rise, ninth bit on wrap
		wrap_up = (st_q.phase >= ers_pkg::PHASE_HI) && (st_q.bit_cnt < ers_pkg::PHASE_LO);
		wrap_down = (st_q.phase < ers_pkg::PHASE_LO) && (st_q.bit_cnt >= ers_pkg::PHASE_HI);
		if (rx_i.tx_8k_rise) begin
			st_d.phase = st_q.bit_cnt;
			st_d.phase_seen = 1'b1;
			if (st_q.phase_seen && (wrap_up || wrap_down)) begin
				st_d.phase_b8 = ~st_q.phase_b8;
			end
		end

		// One-second interval in milliseconds
		if (ms_tick) begin
			st_d.sec_ms = (st_q.sec_ms == ers_pkg::INTERVAL_LAST) ? 10'h000 :
				st_q.sec_ms + 10'h001;
		end

		// CRC error count runs whatever the transmit CRC setting is
		if (maint_enable_i && interval_end) begin
			st_d.crc_cnt = {7'h00, rx_i.crc_error};
		end else if (rx_i.crc_error) begin
			st_d.crc_cnt = st_q.crc_cnt + 8'h01;
		end

		// CRC alignment timeout, armed by regaining basic frame sync
		st_d.prev_frame_lost = rx_i.frame_sync_lost;
		if (rx_i.frame_sync_lost) begin
			st_d.sync_timing = 1'b0;
		end else if (st_q.prev_frame_lost) begin
			st_d.sync_timing = 1'b1;
			st_d.sync_ms = 4'h0;
		end else if (st_q.sync_timing && ms_tick) begin
			if (st_q.sync_ms == ers_pkg::TIMEOUT_LAST) begin
				st_d.sync_timing = 1'b0;
				if (rx_i.crc_multiframe_lost && maint_enable_i) begin
					st_d.crc_timeout = 1'b1;
				end
			end else begin
				st_d.sync_ms = st_q.sync_ms + 4'h1;
			end
		end
		// The clear terms exclude the set term, so no event can be lost here
		if (!rx_i.crc_multiframe_lost || !maint_enable_i) begin
			st_d.crc_timeout = 1'b0;
		end

		// Spare bits refreshed once per multiframe
		if (rx_i.multiframe_pulse) begin
			st_d.spare15 = rx_i.spare_frame15;
			st_d.spare13 = rx_i.spare_frame13;
		end

		// Byte picked for the channel about to start
		unique case (nxt_cnt[7:3])
			ers_pkg::CH_ALIGN: sel = st_q.align_byte;
			ers_pkg::CH_NONALIGN: sel = st_q.nonalign_byte;
			ers_pkg::CH_STATUS1: sel = status1;
			ers_pkg::CH_PHASE: sel = st_q.phase;
			ers_pkg::CH_CRC_CNT: sel = st_q.crc_cnt;
			ers_pkg::CH_STATUS2: sel = status2;
			default: sel = ers_pkg::IDLE_BYTE;
		endcase

		// Serialiser: snapshot at bit 0 so a byte never mixes old and new values
		if (bit_en) begin
			st_d.bit_cnt = nxt_cnt;
			if (nxt_cnt[2:0] == 3'h0) begin
				st_d.shadow = sel;
				st_d.out_bit = sel[7];
			end else begin
				st_d.out_bit = st_q.shadow[3'h7 - nxt_cnt[2:0]];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Stream idles high out of reset
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.out_bit <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign control_status_out_stream_o = st_q.out_bit;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	align_capture_a: assert property (
		rx_i.ts0_valid && rx_i.ts0_alignment |=> st_q.align_byte == $past(rx_i.ts0_byte)
	) else $error("alignment byte not captured");

	fas_toggle_cause_a: assert property (
		$changed(st_q.fas_err_tog) |->
			$past(st_q.fas_err_cnt) == 5'h10 && $past(st_q.holdoff_ms) == 8'h80
	) else $error("alignment error toggle without 16 errors and hold-off");

	slip_toggle_a: assert property (
		rx_i.slip |=> st_q.slip_tog != $past(st_q.slip_tog)
	) else $error("slip did not toggle");

	ext_frame_a: assert property (
		$changed(st_q.ext_sample) |-> $past(frame_edge)
	) else $error("external status changed outside frame pulse");

	phase_capture_a: assert property (
		rx_i.tx_8k_rise |=> st_q.phase == $past(st_q.bit_cnt)
	) else $error("phase not captured at 8 kHz rise");

	crc_wrap_a: assert property (
		rx_i.crc_error && !interval_end && st_q.crc_cnt == 8'hFF |=> st_q.crc_cnt == 8'h00
	) else $error("error count did not wrap");

	crc_clear_a: assert property (
		maint_enable_i && interval_end |=> st_q.crc_cnt <= 8'h01
	) else $error("error count not cleared at interval end");

	marker_fall_a: assert property (
		$fell(marker) |-> st_q.sec_ms == 10'h008 && $past(ms_tick)
	) else $error("interval marker fell at wrong time");

	timeout_clear_a: assert property (
		!maint_enable_i ##1 !maint_enable_i |-> !st_q.crc_timeout
	) else $error("timeout flag held without maintenance");

	snapshot_a: assert property (
		$changed(st_q.shadow) |-> $past(bit_en) && st_q.bit_cnt[2:0] == 3'h0
	) else $error("status byte changed inside a channel");

	// Capture, hold and framing checks on the reported fields, the error and hold-off counts, the idle level and the bit counter
	nonalign_capture_a: assert property (
		rx_i.ts0_valid && !rx_i.ts0_alignment |=> st_q.nonalign_byte == $past(rx_i.ts0_byte)
	) else $error("non-alignment byte not captured");

	align_hold_a: assert property (
		!rx_i.ts0_valid |=> $stable(st_q.align_byte)
	) else $error("alignment byte changed without a new byte");

	slip_quiet_a: assert property (
		!rx_i.slip |=> $stable(st_q.slip_tog)
	) else $error("slip toggle moved without a slip");

	fas_count_cap_a: assert property (
		st_q.fas_err_cnt <= ers_pkg::FAS_ERR_THRESH
	) else $error("alignment error count passed its threshold");

	holdoff_range_a: assert property (
		st_q.holdoff_ms <= ers_pkg::HOLDOFF_DONE
	) else $error("hold-off count passed its end value");

	crc_count_a: assert property (
		rx_i.crc_error && !interval_end |=> st_q.crc_cnt == $past(st_q.crc_cnt) + 8'h01
	) else $error("error count did not step");

	crc_quiet_a: assert property (
		!rx_i.crc_error && !interval_end |=> $stable(st_q.crc_cnt)
	) else $error("error count moved without an error");

	spare_latch_a: assert property (
		rx_i.multiframe_pulse |=> st_q.spare15 == $past(rx_i.spare_frame15) &&
			st_q.spare13 == $past(rx_i.spare_frame13)
	) else $error("spare bits not latched at multiframe");

	spare_hold_a: assert property (
		!rx_i.multiframe_pulse |=> $stable({st_q.spare15, st_q.spare13})
	) else $error("spare bits changed between multiframes");

	marker_rise_a: assert property (
		$rose(marker) |-> st_q.sec_ms == 10'h000
	) else $error("interval marker rose away from interval start");

	timeout_set_a: assert property (
		$rose(st_q.crc_timeout) |-> $past(rx_i.crc_multiframe_lost) && $past(maint_enable_i)
	) else $error("timeout flag set without maintenance and lost sync");

	timeout_lost_a: assert property (
		!rx_i.crc_multiframe_lost |=> !st_q.crc_timeout
	) else $error("timeout flag held after CRC sync found");

	ext_sample_a: assert property (
		frame_edge |=> st_q.ext_sample == $past(st_q.ext_s2)
	) else $error("external status not taken at frame pulse");

	phase_b8_cause_a: assert property (
		$changed(st_q.phase_b8) |-> $past(rx_i.tx_8k_rise)
	) else $error("ninth phase bit changed without a capture");

	idle_channel_a: assert property (
		bit_en && nxt_cnt[2:0] == 3'h0 && nxt_cnt[7:3] < ers_pkg::CH_ALIGN |=> st_q.out_bit
	) else $error("idle channel did not start high");

	frame_restart_a: assert property (
		frame_edge |=> st_q.bit_cnt == 8'h00
	) else $error("bit counter not restarted at frame pulse");

endmodule
`default_nettype wire

// ==== design/ers_pkg.sv ====
// Package: constants, channel map and state carriers of the E1 receive status reporter
package ers_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W = 17;
	localparam int unsigned FAS_HOLDOFF_MS = 128;
	localparam int unsigned CRC_MARK_MS = 8;
	localparam int unsigned CRC_TIMEOUT_MS = 8;
	localparam int unsigned CRC_INTERVAL_MS = 1000;
	localparam logic [7:0] HOLDOFF_DONE = 8'(FAS_HOLDOFF_MS);
	localparam logic [9:0] MARK_END = 10'(CRC_MARK_MS);
	localparam logic [9:0] MARK_LAST = 10'(CRC_MARK_MS - 1);
	localparam logic [9:0] INTERVAL_LAST = 10'(CRC_INTERVAL_MS - 1);
	localparam logic [3:0] TIMEOUT_LAST = 4'(CRC_TIMEOUT_MS - 1);
	localparam logic [4:0] FAS_ERR_THRESH = 5'h10;

	// Channel numbers on the control stream, also the register offsets
	localparam logic [4:0] CH_ALIGN = 5'h10;
	localparam logic [4:0] CH_NONALIGN = 5'h11;
	localparam logic [4:0] CH_STATUS1 = 5'h12;
	localparam logic [4:0] CH_PHASE = 5'h13;
	localparam logic [4:0] CH_CRC_CNT = 5'h14;
	localparam logic [4:0] CH_STATUS2 = 5'h15;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;

	// Primary status byte field positions
	localparam int unsigned S1_FRAME_LOST = 7;
	localparam int unsigned S1_MF_LOST = 6;
	localparam int unsigned S1_FAS_ERR = 5;
	localparam int unsigned S1_SLIP = 4;
	localparam int unsigned S1_AIS = 3;
	localparam int unsigned S1_TS16_AIS = 2;
	localparam int unsigned S1_EXT = 1;
	// Secondary status byte field positions
	localparam int unsigned S2_SPARE15 = 7;
	localparam int unsigned S2_SPARE13 = 6;
	localparam int unsigned S2_MARKER = 3;
	localparam int unsigned S2_CRC_TIMEOUT = 2;
	localparam int unsigned S2_CRC_LOST = 1;
	localparam int unsigned S2_PHASE_B8 = 0;

	// Phase wrap windows: top and bottom quarter of the frame
	localparam logic [7:0] PHASE_HI = 8'hC0;
	localparam logic [7:0] PHASE_LO = 8'h40;

	typedef logic [TICK_W-1:0] ers_tick_cnt_t;

	// Events and levels from the framer core, same clock
	typedef struct packed {
		logic [7:0] ts0_byte;      // Received timeslot 0 byte, bit 1 in MSB
		logic ts0_valid;           // Pulse: ts0_byte is new
		logic ts0_alignment;       // Byte came from an alignment frame
		logic frame_sync_lost;     // Level
		logic multiframe_sync_lost; // Level
		logic fas_error;           // Pulse: one alignment signal error
		logic slip;                // Pulse: controlled slip
		logic all_ones_alarm;      // Level
		logic ts16_all_ones;       // Level
		logic crc_error;           // Pulse: one received CRC error
		logic crc_multiframe_lost; // Level, low once CRC multiframing found
		logic multiframe_pulse;    // Pulse: receive multiframe boundary
		logic spare_frame15;       // Spare bit of frame 15
		logic spare_frame13;       // Spare bit of frame 13
		logic tx_8k_rise;          // Pulse: rising edge of the 8 kHz output
	} ers_rx_t;

	typedef struct packed {
		logic clk_s1, clk_s2, clk_s3;
		logic frm_s1, frm_s2;
		logic ext_s1, ext_s2;
		logic [7:0] bit_cnt;
		logic [7:0] shadow;
		logic out_bit;
		logic [7:0] align_byte;
		logic [7:0] nonalign_byte;
		logic fas_err_tog;
		logic [4:0] fas_err_cnt;
		logic [7:0] holdoff_ms;
		logic slip_tog;
		logic ext_sample;
		logic [7:0] phase;
		logic phase_b8;
		logic phase_seen;
		logic [7:0] crc_cnt;
		logic [9:0] sec_ms;
		logic prev_frame_lost;
		logic sync_timing;
		logic [3:0] sync_ms;
		logic crc_timeout;
		logic spare15;
		logic spare13;
	} ers_state_t;

	typedef struct packed {
		ers_tick_cnt_t cnt;
		logic tick;
	} ers_tick_t;

endpackage

// ==== design/ers_ms_tick.sv ====
// Millisecond enable divider for the status reporter
`timescale 1ns/1ps
`default_nettype none
module ers_ms_tick #(
	parameter int unsigned CYCLES = ers_pkg::CYCLES_PER_MS
) (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_n_i,   // Synchronised reset, active low
	output logic tick_o         // One-cycle pulse every millisecond
);
	localparam ers_pkg::ers_tick_cnt_t LAST = ers_pkg::ers_tick_cnt_t'(CYCLES - 1);

	ers_pkg::ers_tick_t st_q;
	ers_pkg::ers_tick_t st_d;

	// Free-running count, pulse on wrap
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt == LAST) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick_o = st_q.tick;
endmodule
`default_nettype wire

// ==== bench/ers_ctl_model.sv ====
// Controller model: makes the backplane clock and frame pulse, collects channel bytes
`timescale 1ns/1ps
`default_nettype none
module ers_ctl_model (
	input wire logic stream_i, // Control stream from the device
	output logic bp_clk_o, // Backplane bit clock, free running
	output logic bp_frame_o, // Frame pulse, active high
	output logic [7:0] idx_o, // Bit index that the next rise samples
	output logic [15:0] frames_o // Count of frames fully collected
);
	logic [7:0] idx = 8'h00;
	logic [15:0] frm = 16'h0000;
	logic [7:0] sh = 8'h00;
	logic [7:0] ch [0:31];
	assign idx_o = idx;
	assign frames_o = frm;
	////////////////////////////////////////////////////////////////
	// 60 ns bit period keeps the device resync delay inside one bit
	initial begin
		bp_clk_o = 1'b0;
		forever #30 bp_clk_o = ~bp_clk_o;
	end
	// Frame pulse straddles the rise that starts bit 0
	initial bp_frame_o = 1'b0;
	always @(negedge bp_clk_o) begin
		bp_frame_o <= (idx == 8'hFF);
	end
	// A bit stands until the next device bit event, so sample at the rise
	always @(posedge bp_clk_o) begin
		sh = {sh[6:0], stream_i};
		if (idx[2:0] == 3'h7) begin
			ch[idx[7:3]] = sh;
		end
		if (idx == 8'hFF) begin
			frm <= frm + 16'h0001;
		end
		idx <= idx + 8'h01;
	end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the E1 receive status reporter
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, arst_n, ext_pin, maint, stream, bp_clk, bp_frame;
	logic [7:0] idx;
	logic [15:0] frames;
	logic fas_t, slip_t;
	ers_pkg::ers_rx_t rx;
	int bad_count, n_compared;
	ers_status_reporter #(.CYCLES_PER_MS(10)) u_ers_status_reporter (
		.sys_clk_i(sys_clk),
		.arst_n_i(arst_n),
		.bp_clk_i(bp_clk),
		.bp_frame_i(bp_frame),
		.external_status_input_i(ext_pin),
		.maint_enable_i(maint),
		.rx_i(rx),
		.control_status_out_stream_o(stream)
	);
	ers_ctl_model u_ers_ctl_model (
		.stream_i(stream),
		.bp_clk_o(bp_clk),
		.bp_frame_o(bp_frame),
		.idx_o(idx),
		.frames_o(frames)
	);
	////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Waits n frames; callers use at least two, since the first may hold a byte snapshot from before the change
	task automatic fwait(input int n);
		logic [15:0] f0;
		f0 = frames;
		wait (frames == f0 + 16'(n));
		tick(1); // Leave on a clock edge so the next drive is an edge assignment
	endtask
	function automatic logic [7:0] st1();
		return {rx.frame_sync_lost, rx.multiframe_sync_lost, fas_t, slip_t,
			rx.all_ones_alarm, rx.ts16_all_ones, ext_pin, 1'b0};
	endfunction
	task automatic put_ts0(input logic [7:0] b, input logic al);
		rx.ts0_byte <= b;
		rx.ts0_alignment <= al;
		rx.ts0_valid <= 1'b1;
		tick(1);
		rx.ts0_valid <= 1'b0;
		tick(1);
	endtask
	task automatic report_and_stop();
		$display("TB: compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_overhead();
		put_ts0(8'h9B, 1'b1);
		put_ts0(8'h5A, 1'b0);
		fwait(2);
		chk(u_ers_ctl_model.ch[16], 8'h9B);
		chk(u_ers_ctl_model.ch[17], 8'h5A);
		chk(u_ers_ctl_model.ch[0], 8'hFF);
		chk(u_ers_ctl_model.ch[22], 8'hFF);
		put_ts0(8'hE0, 1'b0);
		fwait(2);
		chk(u_ers_ctl_model.ch[16], 8'h9B);
		chk(u_ers_ctl_model.ch[17], 8'hE0);
		$display("TB: overhead done");
	endtask
	task automatic t_status();
		for (int i = 0; i < 2; i++) begin
			rx.frame_sync_lost <= (i == 0);
			rx.multiframe_sync_lost <= (i == 1);
			rx.all_ones_alarm <= (i == 0);
			rx.ts16_all_ones <= (i == 1);
			ext_pin <= (i == 0);
			fwait(2);
			chk(u_ers_ctl_model.ch[18], st1());
		end
		rx.multiframe_sync_lost <= 1'b0;
		rx.ts16_all_ones <= 1'b0;
		$display("TB: status done");
	endtask
	task automatic t_slip();
		rx.slip <= 1'b1;
		tick(1);
		rx.slip <= 1'b0;
		slip_t = ~slip_t;
		fwait(2);
		chk(u_ers_ctl_model.ch[18], st1());
		// Back to back slips cancel out
		rx.slip <= 1'b1;
		tick(2);
		rx.slip <= 1'b0;
		fwait(2);
		chk(u_ers_ctl_model.ch[18], st1());
		$display("TB: slip done");
	endtask
	task automatic t_fas();
		rx.fas_error <= 1'b1;
		tick(16);
		rx.fas_error <= 1'b0;
		fas_t = ~fas_t;
		fwait(2);
		chk(u_ers_ctl_model.ch[18], st1());
		rx.fas_error <= 1'b1;
		tick(15);
		rx.fas_error <= 1'b0;
		fwait(2);
		chk(u_ers_ctl_model.ch[18], st1());
		rx.fas_error <= 1'b1;
		tick(1);
		rx.fas_error <= 1'b0;
		fas_t = ~fas_t;
		fwait(2);
		chk(u_ers_ctl_model.ch[18], st1());
		$display("TB: align errors done");
	endtask
	// Pulse mid-bit so the device counter already shows the model index
	task automatic t_phase();
		logic [7:0] p [0:1];
		p[0] = 8'hF0;
		p[1] = 8'h10;
		for (int i = 0; i < 2; i++) begin
			wait (idx == p[i]);
			tick(4);
			rx.tx_8k_rise <= 1'b1;
			tick(1);
			rx.tx_8k_rise <= 1'b0;
		end
		fwait(2);
		chk(u_ers_ctl_model.ch[19], 8'h10);
		chk(u_ers_ctl_model.ch[21] & 8'h01, 8'h01);
		$display("TB: phase done");
	endtask
	task automatic t_crc();
		rx.crc_error <= 1'b1;
		tick(259);
		rx.crc_error <= 1'b0;
		fwait(2);
		chk(u_ers_ctl_model.ch[20], 8'h03);
		$display("TB: crc count done");
	endtask
	task automatic t_spare();
		rx.spare_frame15 <= 1'b1;
		rx.multiframe_pulse <= 1'b1;
		tick(1);
		rx.multiframe_pulse <= 1'b0;
		rx.spare_frame15 <= 1'b0;
		rx.spare_frame13 <= 1'b1;
		fwait(2);
		chk(u_ers_ctl_model.ch[21] & 8'hC0, 8'h80);
		$display("TB: spare done");
	endtask
	// Timeout flag needs maintenance, a sync regain and CRC sync still missing
	task automatic t_maint();
		maint <= 1'b1;
		rx.crc_multiframe_lost <= 1'b1;
		rx.frame_sync_lost <= 1'b1;
		tick(2);
		rx.frame_sync_lost <= 1'b0;
		fwait(2);
		chk(u_ers_ctl_model.ch[21] & 8'h06, 8'h06);
		rx.crc_multiframe_lost <= 1'b0;
		fwait(2);
		chk(u_ers_ctl_model.ch[21] & 8'h06, 8'h00);
		fwait(6);
		chk(u_ers_ctl_model.ch[20], 8'h00);
		$display("TB: maintenance done");
	endtask
	// Mid-run reset: bytes return to reset values; marker is low one frame after release
	task automatic t_reset();
		arst_n <= 1'b0;
		tick(3);
		arst_n <= 1'b1;
		fas_t = 1'b0;
		slip_t = 1'b0;
		tick(3);
		fwait(2);
		chk(u_ers_ctl_model.ch[16], 8'h00);
		chk(u_ers_ctl_model.ch[18], st1());
		chk(u_ers_ctl_model.ch[19], 8'h00);
		chk(u_ers_ctl_model.ch[20], 8'h00);
		chk(u_ers_ctl_model.ch[21], 8'h00);
		$display("TB: reset done");
	endtask
	////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		tick(99000);
		bad_count++;
		report_and_stop();
	end
	initial begin
		arst_n = 1'b0;
		ext_pin = 1'b0;
		maint = 1'b0;
		rx = '0;
		fas_t = 1'b0;
		slip_t = 1'b0;
		bad_count = 0;
		n_compared = 0;
		tick(5);
		arst_n <= 1'b1;
		tick(3);
		fwait(2);
		t_overhead();
		t_status();
		t_slip();
		t_fas();
		t_phase();
		t_crc();
		t_spare();
		t_maint();
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
